// File: logic/pll_cfg_regs.svh
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH

// Register offsets on the register port.
`define FRAC_LOW_OFS      8'h03
`define FRAC_MID_OFS      8'h04
`define FRAC_HIGH_OFS     8'h05
`define INT_INPUT_SEL_A_OFS  8'h06
`define DIV_MODE_OFS      8'h07
`define AUDIO_IF_OFS      8'h1C

// Field positions.
`define INT_MULT_LSB      0
`define INPUT_SEL_BIT     4
`define POST_DIV_LSB      0
`define FRAC_EN_BIT       2
`define MASTER_DIV_BIT    3
`define AUX_DIV_LSB       4
`define AUDIO_MASTER_BIT  6

// Reset values.
`define FRAC_MULT_RST     22'h36FD21
`define INT_MULT_RST      4'h7
`define INPUT_SEL_RST     1'b0
`define POST_DIV_RST      2'h2
`define FRAC_EN_RST       1'b1
`define MASTER_DIV_RST    1'b0
`define AUX_DIV_RST       2'h1
`define AUDIO_MASTER_RST  1'b0

// Fraction weight and the unit step of the synthesiser budget.
`define FRAC_BITS         22
`define BUDGET_ONE        27'h0400000

// Divider half periods for a post divider select of 0 to 3, in f2 ticks.
`define HALF_SEL0         6'h01
`define HALF_SEL1         6'h02
`define HALF_SEL2         6'h04
`define HALF_SEL3         6'h06
`define HALF_MASTER_RST   6'h04
`define HALF_AUX_RST      6'h04

`endif

// File: logic/pll_cfg_pkg.sv
package pll_cfg_pkg;

	// Software configuration of the synthesiser and its dividers.
	typedef struct packed {
		logic [21:0] frac_mult;
		logic [3:0]  int_mult;
		logic        input_sel_a;
		logic [1:0]  post_divider_sel;
		logic        fractional_enable;
		logic        master_div_sel;
		logic [1:0]  aux_div_sel;
		logic        audio_if_master_sel;
	} cfg_s;

	// Register port request.
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage

// File: logic/clock_div_toggle.sv
`include "pll_cfg_regs.svh"

module clock_div_toggle
	import pll_cfg_pkg::*;
#(
	parameter int            HW        = 6,
	parameter logic [HW-1:0] RESET_HALF = `HALF_MASTER_RST
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic [HW-1:0] half_cnt,
	output logic               clk_o
);

	logic [HW-1:0] cnt_reg,  cnt_next;
	logic [HW-1:0] half_reg, half_next;
	logic          out_reg,  out_next;

	// Count source ticks and toggle at each half period; a new ratio is taken only at the
	// falling edge, so a period is never cut short and no runt pulse leaves the divider.
	always_comb begin
		cnt_next  = cnt_reg;
		half_next = half_reg;
		out_next  = out_reg;
		if (tick) begin
			if (cnt_reg + HW'(1) >= half_reg) begin
				cnt_next = '0;
				out_next = !out_reg;
				if (out_reg)
					half_next = half_cnt;
			end else begin
				cnt_next = cnt_reg + HW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg  <= '0;
			half_reg <= RESET_HALF;
			out_reg  <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			half_reg <= half_next;
			out_reg  <= out_next;
		end
	end

	assign clk_o = out_reg;

	ratio_change_a: assert property (@(posedge clk) disable iff (rst)
		$changed(half_reg) |-> $fell(out_reg))
		else $error("Divider ratio changed away from a period boundary.");

	out_toggle_a: assert property (@(posedge clk) disable iff (rst)
		$changed(out_reg) |-> $past(tick) && $past(cnt_reg) + HW'(1) >= $past(half_reg))
		else $error("Divided clock toggled without a completed half period.");

endmodule

// File: logic/fractional_pll_clock_config.sv
`include "pll_cfg_regs.svh"

module fractional_pll_clock_config
	import pll_cfg_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        REG_WE,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        OSC_CLOCK,
	input  wire logic        SPDIF_RX_EN,
	input  wire logic [1:0]  RX_POST_DIV_SEL,
	input  wire logic        MCLK_I,
	output logic             MCLK_O,
	output logic             MCLK_OE,
	output logic             AUX_CLOCK_PIN,
	output logic             TX_REF_CLK,
	output logic      [25:0] RATIO
);

	reg_req_s    req;
	cfg_s        cfg_reg,    cfg_next;
	logic [7:0]  rdata_reg,  rdata_next;
	logic        osc_s1_reg, osc_s2_reg, osc_prev_reg;
	logic        mck_s1_reg, mck_s2_reg;
	logic        pre_tog_reg, pre_tog_next;
	logic [26:0] budget_reg, budget_next;
	logic [25:0] ratio_reg,  ratio_next;
	logic        tx_ref_reg, tx_ref_next;
	logic        last_sel_reg, last_sel_next;
	logic        last_pass_reg, last_pass_next;
	logic        osc_edge, f1_tick, f2_tick;
	logic [1:0]  eff_post_div;
	logic [5:0]  base_half, master_half, aux_half;
	logic        synth_clock_a, synth_clock_b;

	assign req = '{we: REG_WE, addr: REG_ADDR, wdata: REG_WDATA};

	// Two-stage synchronisers for the oscillator and the master clock pin; only the
	// second stage feeds any logic, keeping metastability out of the edge detector.
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_s1_reg   <= 1'b0;
			osc_s2_reg   <= 1'b0;
			osc_prev_reg <= 1'b0;
			mck_s1_reg   <= 1'b0;
			mck_s2_reg   <= 1'b0;
		end else begin
			osc_s1_reg   <= OSC_CLOCK;
			osc_s2_reg   <= osc_s1_reg;
			osc_prev_reg <= osc_s2_reg;
			mck_s1_reg   <= MCLK_I;
			mck_s2_reg   <= mck_s1_reg;
		end
	end

	assign osc_edge = osc_s2_reg && !osc_prev_reg;

	// The prescaler passes every oscillator edge, or every second one when halving.
	assign f1_tick = osc_edge && (!cfg_reg.input_sel_a || pre_tog_reg);

	// The receiver, when running, owns the post divider select.
	assign eff_post_div = SPDIF_RX_EN ? RX_POST_DIV_SEL : cfg_reg.post_divider_sel;

	// One f2 tick leaves whenever a whole unit of budget is banked; each f1 tick banks
	// the ratio. The average f2 rate is the ratio times f1, valid while f2 stays below CLK.
	assign f2_tick = budget_reg >= `BUDGET_ONE;

	// Register writes, read data and the synthesiser state.
	always_comb begin
		cfg_next     = cfg_reg;
		rdata_next   = 8'h00;
		pre_tog_next = osc_edge ? !pre_tog_reg : pre_tog_reg;
		budget_next  = budget_reg + (f1_tick ? {1'b0, ratio_reg} : 27'h0000000)
			- (f2_tick ? `BUDGET_ONE : 27'h0000000);
		// Integer mode drops the fraction entirely.
		ratio_next   = cfg_reg.fractional_enable ? {cfg_reg.int_mult, cfg_reg.frac_mult}
			: {cfg_reg.int_mult, 22'h000000};
		tx_ref_next  = cfg_reg.audio_if_master_sel ? synth_clock_b : mck_s2_reg;
		// Mode and outcome of the last oscillator edge, kept so the halving can be checked.
		last_sel_next  = osc_edge ? cfg_reg.input_sel_a : last_sel_reg;
		last_pass_next = osc_edge ? f1_tick : last_pass_reg;
		if (req.we) begin
			case (req.addr)
				`FRAC_LOW_OFS: begin
					cfg_next.frac_mult[7:0] = req.wdata;
				end
				`FRAC_MID_OFS: begin
					cfg_next.frac_mult[15:8] = req.wdata;
				end
				`FRAC_HIGH_OFS: begin
					cfg_next.frac_mult[21:16] = req.wdata[5:0];
				end
				`INT_INPUT_SEL_A_OFS: begin
					cfg_next.int_mult    = req.wdata[`INT_MULT_LSB +: 4];
					cfg_next.input_sel_a = req.wdata[`INPUT_SEL_BIT];
				end
				`DIV_MODE_OFS: begin
					cfg_next.post_divider_sel  = req.wdata[`POST_DIV_LSB +: 2];
					cfg_next.fractional_enable = req.wdata[`FRAC_EN_BIT];
					cfg_next.master_div_sel    = req.wdata[`MASTER_DIV_BIT];
					cfg_next.aux_div_sel       = req.wdata[`AUX_DIV_LSB +: 2];
				end
				`AUDIO_IF_OFS: begin
					cfg_next.audio_if_master_sel = req.wdata[`AUDIO_MASTER_BIT];
				end
				default: begin
					cfg_next = cfg_reg;
				end
			endcase
		end
		// Reads return the current value; the divider register shows the select in force,
		// so software can see when the receiver has taken it over.
		case (REG_ADDR)
			`FRAC_LOW_OFS:     rdata_next = cfg_reg.frac_mult[7:0];
			`FRAC_MID_OFS:     rdata_next = cfg_reg.frac_mult[15:8];
			`FRAC_HIGH_OFS:    rdata_next = {2'b00, cfg_reg.frac_mult[21:16]};
			`INT_INPUT_SEL_A_OFS: rdata_next = {3'b000, cfg_reg.input_sel_a, cfg_reg.int_mult};
			`DIV_MODE_OFS:     rdata_next = {2'b00, cfg_reg.aux_div_sel, cfg_reg.master_div_sel,
				cfg_reg.fractional_enable, eff_post_div};
			`AUDIO_IF_OFS:     rdata_next = {1'b0, cfg_reg.audio_if_master_sel, 6'h00};
			default:           rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cfg_reg     <= '{frac_mult: `FRAC_MULT_RST, int_mult: `INT_MULT_RST,
				input_sel_a: `INPUT_SEL_RST, post_divider_sel: `POST_DIV_RST,
				fractional_enable: `FRAC_EN_RST, master_div_sel: `MASTER_DIV_RST,
				aux_div_sel: `AUX_DIV_RST, audio_if_master_sel: `AUDIO_MASTER_RST};
			rdata_reg   <= 8'h00;
			pre_tog_reg <= 1'b0;
			budget_reg  <= 27'h0000000;
			ratio_reg   <= {`INT_MULT_RST, `FRAC_MULT_RST};
			tx_ref_reg  <= 1'b0;
			last_sel_reg  <= 1'b0;
			last_pass_reg <= 1'b0;
		end else begin
			cfg_reg     <= cfg_next;
			rdata_reg   <= rdata_next;
			pre_tog_reg <= pre_tog_next;
			budget_reg  <= budget_next;
			ratio_reg   <= ratio_next;
			tx_ref_reg  <= tx_ref_next;
			last_sel_reg  <= last_sel_next;
			last_pass_reg <= last_pass_next;
		end
	end

	// Half periods in f2 ticks. Master: 1,2,4,6 doubled by the master select. Aux: half,
	// equal, double or four times the master base, except that the smallest stays at one.
	always_comb begin
		case (eff_post_div)
			2'h0:    base_half = `HALF_SEL0;
			2'h1:    base_half = `HALF_SEL1;
			2'h2:    base_half = `HALF_SEL2;
			default: base_half = `HALF_SEL3;
		endcase
		master_half = cfg_reg.master_div_sel ? {base_half[4:0], 1'b0} : base_half;
		case (cfg_reg.aux_div_sel)
			2'h0:    aux_half = (eff_post_div == 2'h0) ? `HALF_SEL0 : {1'b0, base_half[5:1]};
			2'h1:    aux_half = base_half;
			2'h2:    aux_half = {base_half[4:0], 1'b0};
			default: aux_half = {base_half[3:0], 2'b00};
		endcase
	end

	// Master-pin clock divider.
	clock_div_toggle #(
		.HW         (6),
		.RESET_HALF (`HALF_MASTER_RST)
	) u_master_div (
		.clk      (CLK),
		.rst      (RST),
		.tick     (f2_tick),
		.half_cnt (master_half),
		.clk_o    (synth_clock_b)
	);

	// Aux-pin clock divider.
	clock_div_toggle #(
		.HW         (6),
		.RESET_HALF (`HALF_AUX_RST)
	) u_aux_div (
		.clk      (CLK),
		.rst      (RST),
		.tick     (f2_tick),
		.half_cnt (aux_half),
		.clk_o    (synth_clock_a)
	);

	// The divided clocks reach both pins; in master mode the master-pin clock also drives the transmitter reference.
	assign MCLK_O        = synth_clock_b;
	assign MCLK_OE       = cfg_reg.audio_if_master_sel;
	assign AUX_CLOCK_PIN = synth_clock_a;
	assign TX_REF_CLK    = tx_ref_reg;
	assign REG_RDATA     = rdata_reg;
	assign RATIO         = ratio_reg;

	pin_dir_a: assert property (@(posedge CLK) disable iff (RST)
		REG_WE && REG_ADDR == `AUDIO_IF_OFS |=> MCLK_OE == $past(REG_WDATA[`AUDIO_MASTER_BIT]))
		else $error("Master pin direction did not follow the written select.");

	int_mode_a: assert property (@(posedge CLK) disable iff (RST)
		!cfg_reg.fractional_enable |=> RATIO[21:0] == 22'h000000)
		else $error("Fraction used while integer mode selected.");

	frac_sum_a: assert property (@(posedge CLK) disable iff (RST)
		cfg_reg.fractional_enable |=> RATIO == {$past(cfg_reg.int_mult), $past(cfg_reg.frac_mult)})
		else $error("Ratio is not integer plus fraction.");

	rx_force_a: assert property (@(posedge CLK) disable iff (RST)
		SPDIF_RX_EN |=> $past(REG_ADDR) != `DIV_MODE_OFS || REG_RDATA[1:0] == $past(RX_POST_DIV_SEL))
		else $error("Receiver did not own the post divider select.");

	// Two edges in a row in halving mode must alternate between passed and dropped.
	input_sel_a_halve_a: assert property (@(posedge CLK) disable iff (RST)
		osc_edge && cfg_reg.input_sel_a && last_sel_reg |-> f1_tick != last_pass_reg)
		else $error("Halved input did not pass exactly every second edge.");

	pass_through_a: assert property (@(posedge CLK) disable iff (RST)
		osc_edge && !cfg_reg.input_sel_a |-> f1_tick)
		else $error("Undivided input dropped an oscillator edge.");

	f2_budget_a: assert property (@(posedge CLK) disable iff (RST)
		f2_tick && !f1_tick |=> budget_reg == $past(budget_reg) - `BUDGET_ONE)
		else $error("Synthesiser emitted a tick without spending a unit.");

	post_reset_a: assert property (@(posedge CLK)
		$fell(RST) |-> cfg_reg.post_divider_sel == 2'h2 && cfg_reg.fractional_enable)
		else $error("Divider and mode register left reset with wrong values.");

endmodule

// File: verif/fractional_pll_clock_config_tb_top.sv
module fractional_pll_clock_config_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        CLK             = 1'b0;
	logic        RST             = 1'b1;
	logic        REG_WE          = 1'b0;
	logic [7:0]  REG_ADDR        = 8'h00;
	logic [7:0]  REG_WDATA       = 8'h00;
	logic        OSC_CLOCK       = 1'b0;
	logic        SPDIF_RX_EN     = 1'b0;
	logic [1:0]  RX_POST_DIV_SEL = 2'h0;
	logic        MCLK_I          = 1'b0;
	logic [7:0]  REG_RDATA;
	logic        MCLK_O;
	logic        MCLK_OE;
	logic        AUX_CLOCK_PIN;
	logic        TX_REF_CLK;
	logic [25:0] RATIO;
	int          error_cnt       = 0;
	int          checked         = 0;

	// The oscillator runs at an eighth of the clock, so one f1 tick lands every 8 cycles.
	always #50 CLK = ~CLK;
	always #400 OSC_CLOCK = ~OSC_CLOCK;

	fractional_pll_clock_config dut (
		.CLK(CLK), .RST(RST), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .OSC_CLOCK(OSC_CLOCK), .SPDIF_RX_EN(SPDIF_RX_EN),
		.RX_POST_DIV_SEL(RX_POST_DIV_SEL), .MCLK_I(MCLK_I), .MCLK_O(MCLK_O), .MCLK_OE(MCLK_OE),
		.AUX_CLOCK_PIN(AUX_CLOCK_PIN), .TX_REF_CLK(TX_REF_CLK), .RATIO(RATIO)
	);

	// Compares with case equality so an unknown never passes.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test;
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One-cycle write strobe; the trailing release avoids a double assignment at the next edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		#10 REG_WE = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(posedge CLK);
		#10 REG_WE = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
		@(posedge CLK);
		#10 REG_ADDR = a;
		@(posedge CLK);
		#10 chk(name, {24'h0, REG_RDATA}, {24'h0, e});
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return MCLK_O;
			1: return AUX_CLOCK_PIN;
			default: return TX_REF_CLK;
		endcase
	endfunction

	// Cycles across cnt periods of the chosen clock, rising edge to rising edge, bounded so a
	// stuck clock cannot hang.
	task automatic period(input int w, input int cnt, output int n);
		logic p;
		int   k;
		int   c;
		p = pick(w);
		n = -1;
		c = 0;
		for (k = 0; k < 2000; k++) begin
			@(posedge CLK);
			#1;
			if (n >= 0) n++;
			if (pick(w) === 1'b1 && p === 1'b0) begin
				if (n > 0) c++;
				else n = 0;
			end
			if (c == cnt) break;
			p = pick(w);
		end
	endtask

	task automatic t_reset;
		logic [7:0] ra [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1C, 8'h10};
		logic [7:0] re [7] = '{8'h21, 8'hFD, 8'h36, 8'h07, 8'h16, 8'h00, 8'h00};
		chk("ratio", {6'h0, RATIO}, 32'h01F6FD21);
		for (int i = 0; i < 7; i++) rd(ra[i], re[i], "reset");
	endtask

	// In slave mode the pin is an input and the transmitter follows it.
	task automatic t_slave;
		chk("oe", {31'h0, MCLK_OE}, 32'h0);
		MCLK_I = 1'b1;
		repeat (5) @(posedge CLK);
		#10 chk("txref", {31'h0, TX_REF_CLK}, 32'h1);
		MCLK_I = 1'b0;
		repeat (5) @(posedge CLK);
		#10 chk("txref", {31'h0, TX_REF_CLK}, 32'h0);
	endtask

	// R is 8.192, so f2 is 98.304 MHz from a 12 MHz reference: whole part 8, remainder 0C49BA.
	task automatic t_ratio;
		wr(8'h03, 8'hBA);
		wr(8'h04, 8'h49);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h3F, "frac_hi");
		wr(8'h05, 8'h0C);
		wr(8'h06, 8'h08);
		rd(8'h06, 8'h08, "int");
		chk("ratio", {6'h0, RATIO}, {6'h0, 4'h8, 22'h0C49BA});
		wr(8'h07, 8'h12);
		rd(8'h07, 8'h12, "mode");
		chk("ratio_int", {6'h0, RATIO}, {6'h0, 4'h8, 22'h0});
	endtask

	// While the receiver runs its select shows in place of the written one.
	task automatic t_rx;
		wr(8'h07, 8'h16);
		#10 SPDIF_RX_EN = 1'b1;
		for (int s = 0; s < 4; s++) begin
			RX_POST_DIV_SEL = s[1:0];
			rd(8'h07, 8'h14 | 8'(s), "rx_sel");
		end
		SPDIF_RX_EN = 1'b0;
		rd(8'h07, 8'h16, "sw_sel");
	endtask

	// Ratio 8 against an oscillator at an eighth of the clock gives one f2 tick every cycle,
	// so each divided period is a plain count of ticks.
	task automatic t_div;
		int n;
		int base;
		int ah;
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h05, 8'h00);
		wr(8'h06, 8'h08);
		wr(8'h1C, 8'h40);
		rd(8'h1C, 8'h40, "audio_if");
		chk("oe", {31'h0, MCLK_OE}, 32'h1);
		for (int p = 0; p < 4; p++) begin
			for (int m = 0; m < 2; m++) begin
				wr(8'h07, {2'b00, p[1:0], m[0], 1'b1, p[1:0]});
				base = (p == 3) ? 6 : (1 << p);
				ah = (p == 0) ? 1 : ((p == 1) ? base : ((p == 2) ? 2 * base : 4 * base));
				period(0, 1, n);
				period(1, 1, n);
				period(0, 1, n);
				chk("master", n, 2 * base * (m + 1));
				period(1, 1, n);
				chk("aux", n, 2 * ah);
				period(2, 1, n);
				chk("txref", n, 2 * base * (m + 1));
			end
		end
		// Halving f1 leaves bursts of 8 ticks every 16 cycles; 24 ticks span three bursts.
		wr(8'h06, 8'h18);
		wr(8'h07, 8'h1F);
		period(0, 1, n);
		period(0, 1, n);
		chk("input_sel_a", n, 48);
		// R of 5.5 gives 11 ticks in 16 cycles, so 11 periods of two ticks take 32 cycles.
		wr(8'h06, 8'h05);
		wr(8'h05, 8'h20);
		wr(8'h07, 8'h14);
		period(0, 1, n);
		period(0, 11, n);
		chk("frac", n, 32);
		// Without the fraction R is 5, so 5 periods of two ticks take 16 cycles.
		wr(8'h07, 8'h10);
		period(0, 1, n);
		period(0, 5, n);
		chk("int_only", n, 16);
	endtask

	initial begin
		repeat (16) @(posedge CLK);
		#10 RST = 1'b0;
		t_reset;
		t_slave;
		t_ratio;
		t_rx;
		t_div;
		stop_test;
	end

	// The tests take well under 10000 cycles; twice that means something hung.
	initial begin
		#2000000;
		error_cnt++;
		stop_test;
	end
endmodule
